/* design/pabm_pkg.sv */
// Contract
// [R1] Port A: upper pins segments, lower pins commons
// [R2] LCD on: segment pins pull-up, driver, input off
// [R3] Commons overridden by enable and mux select
// [R4] B7 outputs timer2 compare A when direction set
// [R5] B6 outputs timer1 compare B when direction set
// [R6] B5 outputs timer1 compare A when direction set
// [R7] B4 outputs timer0 compare A when direction set
// [R8] Port B pins feed pin-change sources 15..8
// [R9] Pins B3..B0 carry MISO, MOSI, SCK, SS
// [R10] SPI master forces MISO to input
// [R11] SPI slave: MISO direction follows its bit
// [R12] MOSI input as slave, follows bit as master
// [R13] SCK input as slave, follows bit as master
// [R14] Forced input keeps pull-up from port bit
// [R15] Pull-up follows override or dir/out/global-disable
// [R16] Driver follows override value when enabled
// [R17] Digital input follows override regardless of sleep
// [R18] SS input as slave, active low select
// [R19] All overrides combinational, same-cycle change
package pabm_pkg;

  // ==========================================================
  // Pin positions
  localparam int unsigned PABM_PINS = 8;
  localparam int unsigned PABM_SYNC_W = 16;
  localparam int unsigned PABM_FRONT_LO = 4;
  localparam int unsigned PABM_MISO = 3;
  localparam int unsigned PABM_MOSI = 2;
  localparam int unsigned PABM_SCK = 1;
  localparam int unsigned PABM_SS = 0;
  localparam int unsigned PABM_TMR_LO = 4;

  // ==========================================================
  // Values after reset
  localparam logic [1:0] PABM_SYNC_RST = 2'h0;

  // ==========================================================
  // Common line in use when the mux select reaches this index
  localparam logic [1:0] PABM_MUX_BACK1 = 2'h1;
  localparam logic [1:0] PABM_MUX_BACK2 = 2'h2;
  localparam logic [1:0] PABM_MUX_BACK3 = 2'h3;

endpackage : pabm_pkg

/* design/pabm_sync.sv */
// ==========================================================
// Two-stage synchroniser, one per pad input bit
module pabm_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [pabm_pkg::PABM_SYNC_W-1:0] async_in,
  output logic [pabm_pkg::PABM_SYNC_W-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < pabm_pkg::PABM_SYNC_W; gi++)
    begin : g_bit
      logic [1:0] stage_reg;
      logic [1:0] stage_next;

      // Shift in; first stage read only by the second
      always_comb
      begin
        stage_next = {stage_reg[0], async_in[gi]};
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          stage_reg <= pabm_pkg::PABM_SYNC_RST;
        end
        else
        begin
          stage_reg <= stage_next;
        end
      end

      assign sync_out[gi] = stage_reg[1];
    end
  endgenerate

endmodule : pabm_sync

/* design/pabm_mux.sv */
// ==========================================================
// Port A / port B alternate function override and resolve
module pabm_mux
(
  input wire logic clk,
  input wire logic rst,
  input wire logic lcd_enable,
  input wire logic [1:0] lcd_mux_select,
  input wire logic [3:0] lcd_segment_drive,
  input wire logic [3:0] lcd_common_drive,
  input wire logic [7:0] porta_dir,
  input wire logic [7:0] porta_out,
  input wire logic [7:0] portb_dir,
  input wire logic [7:0] portb_out,
  input wire logic pullup_global_disable,
  input wire logic sleep_clamp,
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_master_data_out,
  input wire logic spi_slave_data_out,
  input wire logic spi_sck_out,
  input wire logic [3:0] timer_compare_enable,
  input wire logic [3:0] timer_compare_out,
  input wire logic pin_change_group_enable,
  input wire logic [7:0] pin_change_mask,
  input wire logic [7:0] porta_pad_in,
  input wire logic [7:0] portb_pad_in,
  output logic [7:0] porta_pad_oe,
  output logic [7:0] porta_pad_out,
  output logic [7:0] porta_pullup,
  output logic [7:0] porta_input_enable,
  output logic [7:0] porta_analog_pad_link,
  output logic [7:0] portb_pad_oe,
  output logic [7:0] portb_pad_out,
  output logic [7:0] portb_pullup,
  output logic [7:0] portb_input_enable,
  output logic [7:0] pin_change_source,
  output logic spi_miso_in,
  output logic spi_mosi_in,
  output logic spi_sck_in,
  output logic spi_slave_select_active
);

  // ==========================================================
  // Override signals per pin
  logic [7:0] a_pu_ovr_en;
  logic [7:0] a_dir_ovr_en;
  logic [7:0] a_in_ovr_en;
  logic [7:0] b_pu_ovr_en;
  logic [7:0] b_pu_ovr_val;
  logic [7:0] b_dir_ovr_en;
  logic [7:0] b_val_ovr_en;
  logic [7:0] b_val_ovr_val;
  logic [7:0] b_in_ovr_en;
  logic [3:0] back_used;
  logic spi_as_master;
  logic spi_as_slave;
  logic [15:0] pad_sync;
  logic [7:0] b_alt_digital_input;

  // Commons beyond the mux duty stay plain I/O
  always_comb
  begin
    back_used[0] = 1'b1;
    back_used[1] = lcd_mux_select >= pabm_pkg::PABM_MUX_BACK1; // R3
    back_used[2] = lcd_mux_select >= pabm_pkg::PABM_MUX_BACK2; // R3
    back_used[3] = lcd_mux_select == pabm_pkg::PABM_MUX_BACK3; // R3
  end

  // Port A: all LCD overrides, values zero
  always_comb
  begin
    a_pu_ovr_en[7:4] = {4{lcd_enable}}; // R2
    a_pu_ovr_en[3:0] = {4{lcd_enable}} & back_used; // R3
    a_dir_ovr_en = a_pu_ovr_en;
    a_in_ovr_en = a_pu_ovr_en;
    porta_analog_pad_link = {lcd_segment_drive, lcd_common_drive}; // R1
  end

  // Port B: SPI direction forcing by role
  always_comb
  begin
    spi_as_master = spi_enable & spi_master;
    spi_as_slave = spi_enable & ~spi_master;
    b_dir_ovr_en = '0;
    b_dir_ovr_en[pabm_pkg::PABM_MISO] = spi_as_master; // R10 R11
    b_dir_ovr_en[pabm_pkg::PABM_MOSI] = spi_as_slave; // R12
    b_dir_ovr_en[pabm_pkg::PABM_SCK] = spi_as_slave; // R13
    b_dir_ovr_en[pabm_pkg::PABM_SS] = spi_as_slave; // R18
    b_pu_ovr_en = b_dir_ovr_en;
    // Forced input still honours the port bit for its pull-up
    b_pu_ovr_val = portb_out & {8{~pullup_global_disable}}; // R14
    b_val_ovr_en = '0;
    b_val_ovr_val = '0;
    b_val_ovr_en[7:4] = timer_compare_enable; // R4 R5 R6 R7
    b_val_ovr_val[7:4] = timer_compare_out; // R4 R5 R6 R7
    b_val_ovr_en[pabm_pkg::PABM_MISO] = spi_as_slave; // R9
    b_val_ovr_val[pabm_pkg::PABM_MISO] = spi_slave_data_out; // R9
    b_val_ovr_en[pabm_pkg::PABM_MOSI] = spi_as_master; // R9
    b_val_ovr_val[pabm_pkg::PABM_MOSI] = spi_master_data_out; // R9
    b_val_ovr_en[pabm_pkg::PABM_SCK] = spi_as_master; // R9
    b_val_ovr_val[pabm_pkg::PABM_SCK] = spi_sck_out; // R9
    b_in_ovr_en = pin_change_mask & {8{pin_change_group_enable}}; // R8
  end

  // ==========================================================
  // Generic resolve; no registers so a mode change acts at once
  genvar gi;
  generate
    for (gi = 0; gi < pabm_pkg::PABM_PINS; gi++)
    begin : g_pin
      always_comb
      begin
        // Port A overrides carry zero values
        porta_pullup[gi] = a_pu_ovr_en[gi] ? 1'b0
          : (~porta_dir[gi] & porta_out[gi] & ~pullup_global_disable); // R15 R19
        porta_pad_oe[gi] = a_dir_ovr_en[gi] ? 1'b0 : porta_dir[gi]; // R16 R2
        porta_pad_out[gi] = porta_out[gi];
        porta_input_enable[gi] = a_in_ovr_en[gi] ? 1'b0 : ~sleep_clamp; // R17 R2
        portb_pullup[gi] = b_pu_ovr_en[gi] ? b_pu_ovr_val[gi]
          : (~portb_dir[gi] & portb_out[gi] & ~pullup_global_disable); // R15 R19
        portb_pad_oe[gi] = b_dir_ovr_en[gi] ? 1'b0 : portb_dir[gi]; // R16
        // Timer value only reaches the pad when direction is output
        portb_pad_out[gi] = b_val_ovr_en[gi] ? b_val_ovr_val[gi] : portb_out[gi]; // R4 R5 R6 R7
        portb_input_enable[gi] = b_in_ovr_en[gi] ? 1'b1 : ~sleep_clamp; // R17
      end
    end
  endgenerate

  // ==========================================================
  // Pad inputs come from outside the clock domain
  pabm_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .async_in({portb_pad_in, porta_pad_in}),
    .sync_out(pad_sync)
  );

  // Clamped inputs read as zero
  always_comb
  begin
    b_alt_digital_input = pad_sync[15:8] & portb_input_enable;
    pin_change_source = b_alt_digital_input; // R8
    spi_miso_in = b_alt_digital_input[pabm_pkg::PABM_MISO]; // R9
    spi_mosi_in = b_alt_digital_input[pabm_pkg::PABM_MOSI]; // R9
    spi_sck_in = b_alt_digital_input[pabm_pkg::PABM_SCK]; // R9
    spi_slave_select_active = spi_as_slave & ~b_alt_digital_input[pabm_pkg::PABM_SS]; // R18
  end

  // ==========================================================
  // Checks
  sequence s_master_on;
    spi_enable && spi_master;
  endsequence

  sequence s_slave_on;
    spi_enable && !spi_master;
  endsequence

  AST_LCD_SEG_OFF: assert property (@(posedge clk) disable iff (rst) // R2
    lcd_enable |-> (porta_pad_oe[7:4] == 4'h0 && porta_pullup[7:4] == 4'h0 && porta_input_enable[7:4] == 4'h0))
    else $error("segment pins not released to lcd");

  AST_LCD_BACK0: assert property (@(posedge clk) disable iff (rst) // R3
    lcd_enable |-> (!porta_pad_oe[0] && !porta_pullup[0] && !porta_input_enable[0]))
    else $error("common 0 not released to lcd");

  AST_LCD_BACK3_MUX: assert property (@(posedge clk) disable iff (rst) // R3
    (lcd_enable && lcd_mux_select != 2'h3) |-> (porta_pad_oe[3] == porta_dir[3]))
    else $error("common 3 taken while unused");

  AST_TIMER_PB7: assert property (@(posedge clk) disable iff (rst) // R4
    (timer_compare_enable[3] && portb_dir[7]) |-> (portb_pad_oe[7] && portb_pad_out[7] == timer_compare_out[3]))
    else $error("timer2 compare not on pin 7");

  AST_MISO_MASTER: assert property (@(posedge clk) disable iff (rst) // R10
    s_master_on |-> (!portb_pad_oe[3] && portb_pullup[3] == (portb_out[3] && !pullup_global_disable)))
    else $error("miso not input in master mode");

  AST_MISO_SLAVE: assert property (@(posedge clk) disable iff (rst) // R11
    s_slave_on |-> (portb_pad_oe[3] == portb_dir[3] && portb_pad_out[3] == spi_slave_data_out))
    else $error("miso direction wrong in slave mode");

  AST_SCK_ROLE: assert property (@(posedge clk) disable iff (rst) // R13
    (s_slave_on |-> !portb_pad_oe[1]) and (s_master_on |-> portb_pad_oe[1] == portb_dir[1]))
    else $error("sck direction wrong for role");

  // Slave role and low select held long enough to cross both stages
  sequence s_ss_low_held;
    (spi_enable && !spi_master && pin_change_group_enable && pin_change_mask[0] && !portb_pad_in[0]) [*3];
  endsequence

  AST_SS_SELECT: assert property (@(posedge clk) disable iff (rst) // R18
    s_ss_low_held |-> spi_slave_select_active)
    else $error("slave select low not seen");

  AST_PCINT_PATH: assert property (@(posedge clk) disable iff (rst) // R8
    (!$past(rst) && !$past(rst, 2) && portb_input_enable[7] && $past(portb_input_enable[7])
      && $past(portb_input_enable[7], 2))
      |-> pin_change_source[7] == $past(portb_pad_in[7], 2))
    else $error("pin change source 15 lags wrong");

  AST_MOSI_ROLE: assert property (@(posedge clk) disable iff (rst) // R12
    (s_slave_on |-> !portb_pad_oe[2])
      and (s_master_on |-> (portb_pad_oe[2] == portb_dir[2] && portb_pad_out[2] == spi_master_data_out)))
    else $error("mosi direction wrong for role");

  // Pin change keeps its input alive through sleep
  AST_INPUT_FORCED: assert property (@(posedge clk) disable iff (rst) // R17
    (sleep_clamp && pin_change_group_enable && pin_change_mask[5]) |-> portb_input_enable[5])
    else $error("pin change input clamped in sleep");

  AST_PULLUP_PLAIN: assert property (@(posedge clk) disable iff (rst) // R15
    !spi_enable |-> (portb_pullup == (~portb_dir & portb_out & {8{!pullup_global_disable}})))
    else $error("port b pull-up wrong without overrides");

endmodule : pabm_mux

/* verification/pabm_periph.sv */
// ==========================================================
// Peripheral stand-in: LCD, timer and SPI drive levels
module pabm_periph
(
  input wire logic clk,
  output logic [3:0] lcd_segment_drive,
  output logic [3:0] lcd_common_drive,
  output logic [3:0] timer_compare_out,
  output logic spi_master_data_out,
  output logic spi_slave_data_out,
  output logic spi_sck_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] phase_reg = 8'h00;
  // Steps off the falling edge so levels never move at sampling
  always @(negedge clk)
  begin
    phase_reg <= phase_reg + 8'h01;
  end
  // Bit picks off one counter; spi_sck_out and timer_compare_out[0] share phase_reg[0] and move in lockstep
  assign lcd_segment_drive = phase_reg[3:0] ^ 4'h5;
  assign lcd_common_drive = phase_reg[4:1];
  assign timer_compare_out = {phase_reg[7], phase_reg[2], phase_reg[5], phase_reg[0]};
  assign spi_master_data_out = phase_reg[1];
  assign spi_slave_data_out = phase_reg[3];
  assign spi_sck_out = phase_reg[0];
endmodule : pabm_periph

/* verification/pabm_mux_bench.sv */
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pabm_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a_oe, a_pu, a_ie, a_link, a_out, b_oe, b_pu, b_ie, pcs;
    logic [3:0] b_hi, b_lo;
    logic [2:0] spi;
    logic ssa, pad_ok;
  } pabm_exp_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lcd_enable = 1'b0, pullup_global_disable = 1'b0, sleep_clamp = 1'b0;
  logic spi_enable = 1'b0, spi_master = 1'b0, pin_change_group_enable = 1'b0;
  logic [1:0] lcd_mux_select = 2'h0;
  logic [3:0] lcd_segment_drive, lcd_common_drive, timer_compare_out, timer_compare_enable = 4'h0;
  logic [7:0] porta_dir = 8'h00, porta_out = 8'h00, portb_dir = 8'h00, portb_out = 8'h00;
  logic [7:0] pin_change_mask = 8'h00, porta_pad_in = 8'hff, portb_pad_in = 8'hff;
  logic spi_master_data_out, spi_slave_data_out, spi_sck_out;
  logic [7:0] porta_pad_oe, porta_pad_out, porta_pullup, porta_input_enable, porta_analog_pad_link;
  logic [7:0] portb_pad_oe, portb_pad_out, portb_pullup, portb_input_enable, pin_change_source, ov, fb;
  logic spi_miso_in, spi_mosi_in, spi_sck_in, spi_slave_select_active;
  logic [31:0] rnd = 32'hac20;
  logic [31:0] cyc = 32'h0;
  logic [4:0] mode;
  int error_cnt = 0;
  int n_tests = 0;
  pabm_exp_t exp_q[$];
  pabm_exp_t e;
  pabm_exp_t m;
  always #10 clk = ~clk;
  pabm_periph u_periph (.clk, .lcd_segment_drive, .lcd_common_drive, .timer_compare_out,
    .spi_master_data_out, .spi_slave_data_out, .spi_sck_out);
  pabm_mux u_dut (.clk, .rst, .lcd_enable, .lcd_mux_select, .lcd_segment_drive, .lcd_common_drive,
    .porta_dir, .porta_out, .portb_dir, .portb_out, .pullup_global_disable, .sleep_clamp, .spi_enable,
    .spi_master, .spi_master_data_out, .spi_slave_data_out, .spi_sck_out, .timer_compare_enable,
    .timer_compare_out, .pin_change_group_enable, .pin_change_mask, .porta_pad_in, .portb_pad_in,
    .porta_pad_oe, .porta_pad_out, .porta_pullup, .porta_input_enable, .porta_analog_pad_link,
    .portb_pad_oe, .portb_pad_out, .portb_pullup, .portb_input_enable, .pin_change_source,
    .spi_miso_in, .spi_mosi_in, .spi_sck_in, .spi_slave_select_active);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Driver: one cycle of stimulus, expectation noted alongside
  task automatic step(input logic sweep);
    @(negedge clk);
    rnd = xs(rnd);
    {portb_out, portb_dir, porta_out, porta_dir} = rnd;
    rnd = xs(rnd);
    timer_compare_enable = rnd[3:0];
    pullup_global_disable = rnd[4];
    mode = sweep ? cyc[6:2] : rnd[9:5];
    {lcd_enable, lcd_mux_select} = mode[4:2];
    // Pads and slow modes move every fourth cycle so synced paths settle
    if (cyc[1:0] == 2'h0)
    begin
      rnd = xs(rnd);
      {porta_pad_in, portb_pad_in, pin_change_mask, pin_change_group_enable, sleep_clamp, spi_enable,
        spi_master} = {rnd[25:0], mode[1:0]};
    end
    cyc++;
    #1;
    ov = lcd_enable ? {4'hf, lcd_mux_select >= 2'h3, lcd_mux_select >= 2'h2, lcd_mux_select != 2'h0, 1'b1} : 8'h00;
    fb = {4'h0, spi_enable & spi_master, {3{spi_enable & ~spi_master}}};
    e.a_oe = porta_dir & ~ov;
    e.a_pu = ~porta_dir & porta_out & ~{8{pullup_global_disable}} & ~ov;
    e.a_ie = {8{~sleep_clamp}} & ~ov;
    e.a_link = {lcd_segment_drive, lcd_common_drive};
    e.a_out = porta_out;
    e.b_lo = {fb[0] ? spi_slave_data_out : portb_out[3], fb[3] ? spi_master_data_out : portb_out[2],
      fb[3] ? spi_sck_out : portb_out[1], portb_out[0]};
    e.b_oe = portb_dir & ~fb;
    e.b_pu = ~e.b_oe & portb_out & ~{8{pullup_global_disable}};
    e.b_ie = (pin_change_mask & {8{pin_change_group_enable}}) | {8{~sleep_clamp}};
    e.b_hi = (timer_compare_enable & timer_compare_out) | (~timer_compare_enable & portb_out[7:4]);
    e.pcs = portb_pad_in & e.b_ie;
    // Clamped pads read low; synced value stands from the third edge
    e.spi = portb_pad_in[3:1] & e.b_ie[3:1];
    e.ssa = spi_enable & ~spi_master & ~(portb_pad_in[0] & e.b_ie[0]);
    e.pad_ok = cyc[1] & cyc[0];
    exp_q.push_back(e);
  endtask : step
  // ==========================================================
  // Monitor: oldest note against settled outputs
  always @(posedge clk)
  begin
    if (exp_q.size() > 0)
    begin
      m = exp_q.pop_front();
      `CHK(porta_pad_oe, m.a_oe)
      `CHK(porta_pullup, m.a_pu)
      `CHK(porta_input_enable, m.a_ie)
      `CHK(porta_analog_pad_link, m.a_link)
      `CHK(portb_pad_oe, m.b_oe)
      `CHK(portb_pullup, m.b_pu)
      `CHK(portb_input_enable, m.b_ie)
      `CHK(portb_pad_out[7:4], m.b_hi)
      `CHK(portb_pad_out[3:0], m.b_lo)
      `CHK(porta_pad_out, m.a_out)
      if (m.pad_ok)
      begin
        `CHK(pin_change_source, m.pcs)
        `CHK({spi_miso_in, spi_mosi_in, spi_sck_in}, m.spi)
        `CHK(spi_slave_select_active, m.ssa)
      end
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    `CHK(pin_change_source, 8'h00)
    rst = 1'b0;
    $display("test reset done");
    repeat (3) @(negedge clk);
    // Every LCD duty and SPI role, then free random modes
    repeat (128) step(1'b1);
    $display("test mode sweep done");
    repeat (400) step(1'b0);
    $display("test random modes done");
    repeat (4)
      @(negedge clk);
    if (exp_q.size() != 0)
      error_cnt++;
    wrap_up();
  end
endmodule : pabm_mux_bench
